//--- rtl/acd_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 32-bit AHB-Lite register port, one 200 MHz clock
// Notes: byte offsets, field positions, reset values and cycle counts
package acd_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_SLOT_A = 8'h00;
  localparam logic [7:0] ADDR_SLOT_B = 8'h04;
  localparam logic [7:0] ADDR_CFG1 = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  // channel control slot fields
  localparam int DIFF_BIT = 5;
  localparam int SEL_MSB = 4;
  // converter_config_one fields
  localparam int CFG_LPC_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LSMP_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_SRC_LSB = 0;
  // control register fields
  localparam int CTRL_TRG_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  // reset values
  localparam logic [5:0] SLOT_RST = 6'h1F;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [4:0] SEL_OFF = 5'h1F;
  // timing counts in conversion clock cycles
  localparam logic [4:0] SHORT_SAMPLE_CYC = 5'h04;
  localparam logic [4:0] LONG_SAMPLE_CYC = 5'h18;
  localparam logic [4:0] DIFF_EXTRA_CYC = 5'h04;
  // internal oscillator stand-in, in bus cycles
  localparam logic [2:0] ASYNC_DIV_CYC = 3'h4;
  // clock source codes
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV = 3'b100
  } acd_state_t;

  typedef enum logic [3:0] {
    IN_PAIR_DIFF = 4'h0,
    IN_PAIR_PLUS = 4'h1,
    IN_SINGLE = 4'h2,
    IN_TEMP = 4'h3,
    IN_BGAP = 4'h4,
    IN_REFH = 4'h5,
    IN_REFL = 4'h6,
    IN_OFF = 4'h7,
    IN_RSVD = 4'h8
  } acd_input_t;
endpackage

//--- rtl/acd_clk_if.sv
// Purpose: carries clock source choice and conversion tick
// Assumes: both ends on the bus clock
// Notes: tick is a one-cycle enable, never a real clock
`timescale 1ns/1ps
interface acd_clk_if;
  logic [1:0] src_sel;
  logic [1:0] div_sel;
  logic run;
  logic tick;
  modport ctl (output src_sel, output div_sel, output run, input tick);
  modport gen (input src_sel, input div_sel, input run, output tick);
endinterface

//--- rtl/acd_decode.sv
// Purpose: decodes one channel control slot and the resolution mode
// Assumes: purely combinational
// Notes: instantiated once per slot
`timescale 1ns/1ps
module acd_decode (
  input wire logic diff,
  input wire logic [4:0] sel,
  input wire logic [1:0] mode,
  output acd_pkg::acd_input_t kind,
  output logic [4:0] res_bits,
  output logic twos_comp
);
  // selector meaning depends on the differential enable
  always_comb begin
    if (sel == acd_pkg::SEL_OFF) begin
      kind = acd_pkg::IN_OFF;
    end else if (sel <= 5'h03) begin
      kind = diff ? acd_pkg::IN_PAIR_DIFF : acd_pkg::IN_PAIR_PLUS;
    end else if (sel <= 5'h17) begin
      kind = diff ? acd_pkg::IN_RSVD : acd_pkg::IN_SINGLE;
    end else if (sel == 5'h1A) begin
      kind = acd_pkg::IN_TEMP;
    end else if (sel == 5'h1B) begin
      kind = acd_pkg::IN_BGAP;
    end else if (sel == 5'h1D) begin
      kind = acd_pkg::IN_REFH; // negated high reference when diff
    end else if (sel == 5'h1E) begin
      kind = diff ? acd_pkg::IN_RSVD : acd_pkg::IN_REFL;
    end else begin
      kind = acd_pkg::IN_RSVD;
    end
  end

  // resolution from mode plus differential enable
  always_comb begin
    case (mode)
      2'h0: res_bits = diff ? 5'h09 : 5'h08;
      2'h1: res_bits = diff ? 5'h0D : 5'h0C;
      2'h2: res_bits = diff ? 5'h0B : 5'h0A;
      default: res_bits = 5'h10;
    endcase
    twos_comp = diff;
  end
endmodule

//--- rtl/acd_clkgen.sv
// Purpose: picks the conversion clock source and divides it
// Assumes: alternate clock pin is asynchronous and slow against clk
// Notes: output is an enable pulse at the conversion clock rate
`timescale 1ns/1ps
module acd_clkgen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic alternate_clock,
  acd_clk_if.gen cg
);
  logic alt1_q, alt2_q, alt3_q;
  logic half_q, half_d;
  logic [2:0] osc_q, osc_d;
  logic [2:0] div_q, div_d;
  logic [2:0] div_max;
  logic src_en;

  // last count of the oscillator stand-in
  localparam logic [2:0] ASYNC_LAST = 3'(acd_pkg::ASYNC_DIV_CYC - 3'h1);

  // source enable, divider and oscillator next values
  always_comb begin
    half_d = ~half_q;
    osc_d = 3'h0;
    // oscillator only runs while selected and converting, like the real one
    if (cg.run && cg.src_sel == acd_pkg::SRC_ASYNC && osc_q != ASYNC_LAST) begin
      osc_d = 3'(osc_q + 3'h1);
    end
    case (cg.src_sel)
      acd_pkg::SRC_BUS: src_en = 1'b1;
      acd_pkg::SRC_BUS_HALF: src_en = half_q;
      acd_pkg::SRC_ALT: src_en = alt2_q & ~alt3_q;
      default: src_en = (osc_q == ASYNC_LAST);
    endcase
    case (cg.div_sel)
      2'h0: div_max = 3'h0;
      2'h1: div_max = 3'h1;
      2'h2: div_max = 3'h3;
      default: div_max = 3'h7;
    endcase
    div_d = div_q;
    if (!cg.run) begin
      div_d = 3'h0;
    end else if (src_en) begin
      div_d = (div_q == div_max) ? 3'h0 : 3'(div_q + 3'h1);
    end
    cg.tick = cg.run && src_en && (div_q == div_max);
  end

  // pin synchroniser and counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt1_q <= 1'b0;
      alt2_q <= 1'b0;
      alt3_q <= 1'b0;
      half_q <= 1'b0;
      osc_q <= 3'h0;
      div_q <= 3'h0;
    end else begin
      alt1_q <= alternate_clock;
      alt2_q <= alt1_q;
      alt3_q <= alt2_q;
      half_q <= half_d;
      osc_q <= osc_d;
      div_q <= div_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_div8;
    (cg.run && cg.tick && cg.src_sel == acd_pkg::SRC_BUS && cg.div_sel == 2'h3)
      |=> !cg.tick [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 ticks too soon");

  property p_half;
    (cg.run && $past(cg.run) && cg.src_sel == acd_pkg::SRC_BUS_HALF
      && $stable(cg.src_sel) && cg.div_sel == 2'h0) |-> (cg.tick != $past(cg.tick));
  endproperty
  a_half: assert property (p_half) else $error("halved bus clock not alternating");
endmodule

//--- rtl/acd_top.sv
// Purpose: channel and configuration control of a successive approximation converter
// Assumes: AHB-Lite slave with zero wait states, analog side beyond afe_ ports
// Notes: results, completion flags and calibration live elsewhere
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module acd_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic alternate_clock,
  input wire logic hw_trigger,
  output logic afe_power_en,
  output logic afe_isolate,
  output logic [4:0] afe_input_sel,
  output logic [3:0] afe_input_kind,
  output logic afe_diff,
  output logic afe_low_power,
  output logic afe_long_sample,
  output logic afe_sample,
  output logic [4:0] afe_res_bits,
  output logic afe_twos_comp,
  output logic afe_conv_tick,
  output logic conv_done
);
  // word address match, shared by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic rs1_q, rs2_q, rst_n;

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_n = rs2_q;

  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [5:0] slot_q [2];
  logic [5:0] slot_d [2];
  logic [7:0] cfg1_q, cfg1_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [1:0] we_slot;
  logic ap_take;
  logic [31:0] rd_val;

  acd_pkg::acd_state_t state_q, state_d;
  logic act_q, act_d;
  logic [4:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic hw_nxt_q, hw_nxt_d;
  logic [4:0] sel_q, sel_d;
  logic diff_q, diff_d;
  logic trg1_q, trg2_q, trg3_q;

  acd_pkg::acd_input_t kind [2];
  logic [4:0] res [2];
  logic [1:0] tc;
  logic [1:0] rsvd;
  logic [4:0] sample_len, conv_len;
  logic trig_sel, cont_en, sw_start, hw_start, abort, tick;

  acd_clk_if cg ();

  assign ap_take = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign we_slot[0] = wr_pend_q && hit(wr_addr_q, acd_pkg::ADDR_SLOT_A);
  assign we_slot[1] = wr_pend_q && hit(wr_addr_q, acd_pkg::ADDR_SLOT_B);
  assign trig_sel = ctrl_q[acd_pkg::CTRL_TRG_BIT];
  assign cont_en = ctrl_q[acd_pkg::CTRL_CONT_BIT];

  // per-slot decoders
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_slot
      acd_decode u_dec (
        .diff(slot_q[gi][acd_pkg::DIFF_BIT]),
        .sel(slot_q[gi][acd_pkg::SEL_MSB:0]),
        .mode(cfg1_q[acd_pkg::CFG_MODE_LSB +: 2]),
        .kind(kind[gi]),
        .res_bits(res[gi]),
        .twos_comp(tc[gi])
      );
      assign rsvd[gi] = (kind[gi] == acd_pkg::IN_RSVD);
    end
  endgenerate

  // read mux; unmapped words read zero
  always_comb begin
    rd_val = 32'h0;
    if (hit(haddr[7:0], acd_pkg::ADDR_SLOT_A)) begin
      rd_val = {26'h0, slot_q[0]};
    end else if (hit(haddr[7:0], acd_pkg::ADDR_SLOT_B)) begin
      rd_val = {26'h0, slot_q[1]};
    end else if (hit(haddr[7:0], acd_pkg::ADDR_CFG1)) begin
      rd_val = {24'h0, cfg1_q};
    end else if (hit(haddr[7:0], acd_pkg::ADDR_CTRL)) begin
      rd_val = {30'h0, ctrl_q};
    end else if (hit(haddr[7:0], acd_pkg::ADDR_STAT)) begin
      rd_val = {19'h0, res[act_q], 3'h0, rsvd, diff_q, act_q, afe_power_en};
    end
  end

  // bus slave next values; writes land in the data phase
  always_comb begin
    wr_pend_d = ap_take && hwrite;
    wr_addr_d = ap_take ? haddr[7:0] : wr_addr_q;
    hrdata_d = (ap_take && !hwrite) ? rd_val : hrdata_q;
    slot_d = slot_q;
    cfg1_d = cfg1_q;
    ctrl_d = ctrl_q;
    for (int i = 0; i < 2; i++) begin
      if (we_slot[i]) begin
        slot_d[i] = hwdata[5:0];
      end
    end
    if (wr_pend_q && hit(wr_addr_q, acd_pkg::ADDR_CFG1)) begin
      cfg1_d = hwdata[7:0];
    end
    if (wr_pend_q && hit(wr_addr_q, acd_pkg::ADDR_CTRL)) begin
      ctrl_d = hwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0;
      slot_q[0] <= acd_pkg::SLOT_RST;
      slot_q[1] <= acd_pkg::SLOT_RST;
      cfg1_q <= acd_pkg::CFG1_RST;
      ctrl_q <= acd_pkg::CTRL_RST;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      slot_q <= slot_d;
      cfg1_q <= cfg1_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // clock source and divider
  assign cg.src_sel = cfg1_q[acd_pkg::CFG_SRC_LSB +: 2];
  assign cg.div_sel = cfg1_q[acd_pkg::CFG_DIV_LSB +: 2];
  assign cg.run = (state_q != acd_pkg::ST_IDLE);
  assign tick = cg.tick;

  acd_clkgen u_clk (
    .clk(clk),
    .rst_n(rst_n),
    .alternate_clock(alternate_clock),
    .cg(cg)
  );

  // phase lengths; differential adds its own cycles
  assign sample_len = cfg1_q[acd_pkg::CFG_LSMP_BIT] ? acd_pkg::LONG_SAMPLE_CYC
                                                    : acd_pkg::SHORT_SAMPLE_CYC;
  assign conv_len = diff_q ? 5'(res[act_q] + acd_pkg::DIFF_EXTRA_CYC)
                           : res[act_q];

  // trigger decode; software start checks the selector being written, hardware start the stored slot selector
  assign sw_start = !trig_sel && we_slot[0]
                    && (hwdata[acd_pkg::SEL_MSB:0] != acd_pkg::SEL_OFF);
  assign hw_start = trig_sel && trg2_q && !trg3_q
                    && (slot_q[hw_nxt_q][acd_pkg::SEL_MSB:0] != acd_pkg::SEL_OFF);
  assign abort = (state_q != acd_pkg::ST_IDLE) && we_slot[act_q];

  // sequencer next values
  always_comb begin
    state_d = state_q;
    act_d = act_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    hw_nxt_d = hw_nxt_q;
    case (state_q)
      acd_pkg::ST_IDLE: begin
        if (hw_start) begin
          state_d = acd_pkg::ST_SAMPLE;
          act_d = hw_nxt_q;
          hw_nxt_d = ~hw_nxt_q; // ping-pong between the two slots
          cnt_d = 5'h00;
        end
      end
      acd_pkg::ST_SAMPLE: begin
        if (tick) begin
          cnt_d = 5'(cnt_q + 5'h01);
          if (cnt_q == 5'(sample_len - 5'h01)) begin
            state_d = acd_pkg::ST_CONV;
            cnt_d = 5'h00;
          end
        end
      end
      acd_pkg::ST_CONV: begin
        if (tick) begin
          cnt_d = 5'(cnt_q + 5'h01);
          if (cnt_q == 5'(conv_len - 5'h01)) begin
            done_d = 1'b1;
            cnt_d = 5'h00;
            // single mode drops straight to low power
            state_d = cont_en ? acd_pkg::ST_SAMPLE : acd_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_d = acd_pkg::ST_IDLE;
      end
    endcase
    if (abort) begin
      state_d = acd_pkg::ST_IDLE; // all-ones write ends here, no tail conversion
      done_d = 1'b0;
      cnt_d = 5'h00;
    end
    if (sw_start) begin
      state_d = acd_pkg::ST_SAMPLE;
      act_d = 1'b0;
      cnt_d = 5'h00;
    end
    if (state_d == acd_pkg::ST_IDLE) begin
      sel_d = acd_pkg::SEL_OFF;
      diff_d = 1'b0;
    end else begin
      sel_d = slot_d[act_d][acd_pkg::SEL_MSB:0];
      diff_d = slot_d[act_d][acd_pkg::DIFF_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= acd_pkg::ST_IDLE;
      act_q <= 1'b0;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
      hw_nxt_q <= 1'b0;
      sel_q <= acd_pkg::SEL_OFF;
      diff_q <= 1'b0;
      trg1_q <= 1'b0;
      trg2_q <= 1'b0;
      trg3_q <= 1'b0;
    end else begin
      state_q <= state_d;
      act_q <= act_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      hw_nxt_q <= hw_nxt_d;
      sel_q <= sel_d;
      diff_q <= diff_d;
      trg1_q <= hw_trigger;
      trg2_q <= trg1_q;
      trg3_q <= trg2_q;
    end
  end

  // analog side controls
  assign afe_power_en = (state_q != acd_pkg::ST_IDLE);
  assign afe_isolate = ~afe_power_en;
  assign afe_input_sel = sel_q;
  assign afe_input_kind = afe_power_en ? kind[act_q] : acd_pkg::IN_OFF;
  assign afe_diff = diff_q;
  assign afe_low_power = cfg1_q[acd_pkg::CFG_LPC_BIT];
  assign afe_long_sample = cfg1_q[acd_pkg::CFG_LSMP_BIT];
  assign afe_sample = (state_q == acd_pkg::ST_SAMPLE);
  assign afe_res_bits = res[act_q];
  assign afe_twos_comp = tc[act_q];
  assign afe_conv_tick = tick;
  assign conv_done = done_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_off;
    afe_power_en |-> (afe_input_sel != acd_pkg::SEL_OFF);
  endproperty
  a_off: assert property (p_off) else $error("converter powered on all-ones code");

  property p_sw_start;
    sw_start |=> afe_power_en && afe_sample && !act_q && cnt_q == 5'h00;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("slot A write did not start");

  property p_halt;
    (abort && we_slot[act_q] && hwdata[4:0] == acd_pkg::SEL_OFF && !trig_sel)
      |=> !afe_power_en [*3];
  endproperty
  a_halt: assert property (p_halt) else $error("conversion after all-ones halt");

  property p_single_end;
    (state_q == acd_pkg::ST_CONV && state_d != acd_pkg::ST_CONV && !cont_en && !sw_start
      && !abort) |=> conv_done && !afe_power_en;
  endproperty
  a_single_end: assert property (p_single_end) else $error("no power down after single");

  property p_diff_res;
    afe_power_en && afe_diff |-> afe_twos_comp && (afe_res_bits[0] || afe_res_bits == 5'h10);
  endproperty
  a_diff_res: assert property (p_diff_res) else $error("differential resolution wrong");

  property p_diff_pair;
    afe_power_en && afe_diff && afe_input_sel <= 5'h03 |-> afe_input_kind == acd_pkg::IN_PAIR_DIFF;
  endproperty
  a_diff_pair: assert property (p_diff_pair) else $error("differential pair decode wrong");

  property p_short_sample;
    $rose(afe_sample) && !afe_long_sample && cg.src_sel == 2'h0 && cg.div_sel == 2'h0
      ##1 (!we_slot[act_q] && $stable(cfg1_q)) [*4] |-> !afe_sample;
  endproperty
  a_short_sample: assert property (p_short_sample) else $error("short sample length wrong");

  c_diff_done: cover property (afe_diff && done_d);
  c_abort: cover property (abort && sw_start);
  c_cont: cover property (conv_done && afe_sample);
endmodule

//--- tb/acd_afe_model.sv
// Purpose: stand-in for the analog converter and input mux
// Assumes: watches the afe_ outputs on the bus clock
// Notes: passive; counts ticks, tick spacing, completions and faults
`timescale 1ns/1ps
module acd_afe_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic power_en,
  input wire logic isolate,
  input wire logic tick,
  input wire logic done,
  output int ticks,
  output int gap,
  output int dones,
  output int faults
);
  int cyc;
  int last;
  // gap holds the spacing of the last two ticks, so only long runs mean anything
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (clr) begin
      ticks <= 0;
      dones <= 0;
      faults <= 0;
    end else begin
      if (tick) begin
        ticks <= ticks + 1;
        gap <= cyc - last;
        last <= cyc;
      end
      if (done) dones <= dones + 1;
      if (tick && !power_en) faults <= faults + 1;
      if (isolate === power_en) faults <= faults + 1;
    end
  end
endmodule

//--- tb/test_adc_channel_and_config_decode.sv
// Purpose: self-checking bench of the converter control block
// Assumes: zero wait state slave, alternate clock 10 MHz free running
// Notes: expectations come from the selector and config field tables
`timescale 1ns/1ps
module test_adc_channel_and_config_decode;
  logic clk, rstn, hsel, hwrite, alt_clk, hw_trigger, clr;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, power_en, isolate, diff, low_power, long_sample, sample, twos;
  logic tick, done;
  logic [4:0] sel, res_bits;
  logic [3:0] kind;
  int ticks, gap, dones, faults, err_count, samples_checked, n;

  acd_top u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .alternate_clock(alt_clk), .hw_trigger(hw_trigger),
    .afe_power_en(power_en), .afe_isolate(isolate), .afe_input_sel(sel),
    .afe_input_kind(kind), .afe_diff(diff), .afe_low_power(low_power),
    .afe_long_sample(long_sample), .afe_sample(sample), .afe_res_bits(res_bits),
    .afe_twos_comp(twos), .afe_conv_tick(tick), .conv_done(done));

  acd_afe_model u_afe (.clk(clk), .clr(clr), .power_en(power_en), .isolate(isolate),
    .tick(tick), .done(done), .ticks(ticks), .gap(gap), .dones(dones), .faults(faults));

  // clocks; alternate edges kept off the bus clock edges
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    alt_clk = 1'b0;
    #1.3;
    forever #50 alt_clk = ~alt_clk;
  end

  task automatic test_done;
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // one single word transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string w);
    bus(1'b0, a, 32'h00000000, x);
    check(x, exp, w);
  endtask

  // bounded wait for the completion pulse
  task automatic wait_done;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 3000);
    // a missing completion is a mismatch, not a silent return
    if (done !== 1'b1) begin
      err_count++;
      $display("BAD %0t no completion pulse", $time);
    end
  endtask

  function automatic logic [3:0] exp_kind(input logic d, input logic [4:0] s);
    if (s == 5'h1F) return 4'h7;
    if (s < 5'h04) return d ? 4'h0 : 4'h1;
    if (s < 5'h18) return d ? 4'h8 : 4'h2;
    if (s == 5'h1A) return 4'h3;
    if (s == 5'h1B) return 4'h4;
    if (s == 5'h1D) return 4'h5;
    if (s == 5'h1E && !d) return 4'h6;
    return 4'h8;
  endfunction

  task automatic t_reset;
    rd_chk(acd_pkg::ADDR_SLOT_A, 32'h0000001F, "slot a reset");
    rd_chk(acd_pkg::ADDR_SLOT_B, 32'h0000001F, "slot b reset");
    rd_chk(acd_pkg::ADDR_CFG1, 32'h00000000, "cfg reset");
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h00000000, "unmapped read");
    check({hreadyout, hresp, power_en, isolate, kind}, 8'h97, "idle outputs");
  endtask

  // every selector code with both settings of the differential bit
  task automatic t_decode;
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 32; s++) begin
        wr(acd_pkg::ADDR_SLOT_A, 32'(d * 32 + s));
        #1;
        check(kind, exp_kind(d[0], s[4:0]), "input kind");
        check({sel, diff}, {s[4:0], d[0] && s != 31}, "sel diff");
        check(power_en, s != 31, "power on write");
        // status word: resolution, slot a reserved flag, diff, active slot a, busy
        rd_chk(acd_pkg::ADDR_STAT, {19'h0, (d[0] ? 5'h09 : 5'h08), 4'h0,
               exp_kind(d[0], s[4:0]) == 4'h8, d[0] && s != 31, 1'b0, s != 31},
               "status word");
      end
    end
  endtask

  task automatic t_res;
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr(acd_pkg::ADDR_CFG1, 32'(m * 4));
        wr(acd_pkg::ADDR_SLOT_A, 32'(d * 32));
        #1;
        check(res_bits, m == 3 ? 16 : (m == 0 ? 8 : (m == 1 ? 12 : 10)) + d, "res");
        check(twos, d[0], "twos comp");
      end
    end
    wr(acd_pkg::ADDR_SLOT_A, 32'h0000001F);
  endtask

  // one full conversion under a given configuration
  task automatic t_timing(input logic [7:0] cfg, input logic d, input int exp_t, input int exp_g);
    wr(acd_pkg::ADDR_CFG1, {24'h000000, cfg});
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wr(acd_pkg::ADDR_SLOT_A, {26'h0, d, 5'h00});
    #1;
    check({sample, low_power, long_sample}, {1'b1, cfg[7], cfg[4]}, "cfg bits");
    wait_done;
    repeat (2) @(posedge clk);
    #1;
    check(power_en, 1'b0, "power after done");
    check(ticks, exp_t, "tick count");
    check(gap, exp_g, "tick spacing");
    check(dones, 32'h00000001, "done count");
    check(faults, 32'h00000000, "model faults");
  endtask

  task automatic t_cont_abort;
    wr(acd_pkg::ADDR_CFG1, 32'h00000000);
    wr(acd_pkg::ADDR_CTRL, 32'h00000002);
    wr(acd_pkg::ADDR_SLOT_A, 32'h00000002);
    wait_done;
    #1;
    check(power_en, 1'b1, "continuous restart");
    wr(acd_pkg::ADDR_SLOT_A, 32'h0000001F);
    #1;
    check({power_en, isolate}, 2'h1, "halt powers off");
    n = dones;
    repeat (100) @(posedge clk);
    check(dones, n, "no extra conversion");
    wr(acd_pkg::ADDR_CTRL, 32'h00000000);
    wr(acd_pkg::ADDR_SLOT_B, 32'h00000004);
    #1;
    check(power_en, 1'b0, "slot b no start");
  endtask

  // hardware trigger mode: a slot write alone must not start
  task automatic t_hw;
    wr(acd_pkg::ADDR_CTRL, 32'h00000001);
    wr(acd_pkg::ADDR_SLOT_A, 32'h00000005);
    #1;
    check(power_en, 1'b0, "hw mode write");
    @(posedge clk);
    hw_trigger <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (power_en !== 1'b1 && n < 20);
    hw_trigger <= 1'b0;
    check(sel, 5'h05, "hw start");
    wait_done;
    wr(acd_pkg::ADDR_CTRL, 32'h00000000);
  endtask

  initial begin
    {hsel, hwrite, hw_trigger, clr} = 4'h0;
    {haddr, hwdata, htrans, hsize} = '0;
    {err_count, samples_checked} = 0;
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_decode;
    t_res;
    t_timing(8'h00, 1'b0, 12, 1);
    t_timing(8'h94, 1'b0, 36, 1);
    t_timing(8'h00, 1'b1, 17, 1);
    t_timing(8'h60, 1'b0, 12, 8);
    t_timing(8'h01, 1'b0, 12, 2);
    t_timing(8'h21, 1'b0, 12, 4);
    t_timing(8'h43, 1'b0, 12, 16);
    t_timing(8'h02, 1'b0, 12, 20);
    t_cont_abort;
    t_hw;
    test_done;
  end

  // watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    test_done;
  end
endmodule
